// ---- core/pcw_pkg.sv ----
// pcw_pkg: constants and carrier types for the pwm cycle configuration block
// assumes a byte-wide special-function-register bus with one-cycle strobes
package pcw_pkg;
    localparam logic [7:0] PCW_CFG_ADDR     = 8'hF7;
    localparam logic [7:0] PCW_CFG_RESET    = 8'h00;
    localparam int         PCW_BANK_BIT     = 7;
    localparam int         PCW_IRQEN_BIT    = 6;
    localparam int         PCW_FLAG_BIT     = 5;
    localparam int         PCW_UNUSED_BIT   = 4;
    localparam int         PCW_RELOAD_BIT   = 3;
    localparam int         PCW_CYCLE_LENGTH_SELECT_MSB    = 2;
    localparam int         PCW_CYCLE_LENGTH_SELECT_W      = 3;
    localparam int         PCW_MIN_CYCLE    = 8;
    localparam int         PCW_CNT_W        = 16;
    localparam int         PCW_CH_COUNT     = 3;
    localparam logic [2:0] PCW_CYCLE_LENGTH_SELECT_RESET  = 3'h0;

    typedef enum logic [1:0] {
        PCW_MODE_OTHER,
        PCW_MODE_NBIT,
        PCW_MODE_WIDE
    } pcw_mode_type;

    typedef struct packed {
        logic                   bank_sel;
        logic                   irq_en;
        logic                   reload_en;
        logic [PCW_CYCLE_LENGTH_SELECT_W-1:0] cycle_length_select;
    } pcw_ctrl_type;
endpackage : pcw_pkg

// ---- core/pcw_reload_mem.sv ----
// pcw_reload_mem: per-channel 16-bit auto-reload value store
// assumes writes come from the register front end on the same clock
module pcw_reload_mem
    import pcw_pkg::*;
#(
    parameter int CH = PCW_CH_COUNT
)
(
    // clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    rst_n,
    // write port, byte lanes
    input  wire logic                    wr_lo,
    input  wire logic                    wr_hi,
    input  wire logic [$clog2(CH)-1:0]   wr_ch,
    input  wire logic [7:0]              wr_data,
    // registered read of all channels
    output logic      [CH*PCW_CNT_W-1:0] rd_all
);
    logic [PCW_CNT_W-1:0] mem_q [CH];

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < CH; i++)
                mem_q[i] <= '0;
        end
        else
        begin
            if (wr_lo)
                mem_q[wr_ch][7:0] <= wr_data;
            if (wr_hi)
                mem_q[wr_ch][15:8] <= wr_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            rd_all <= '0;
        else
            for (int i = 0; i < CH; i++)
                rd_all[i*PCW_CNT_W +: PCW_CNT_W] <= mem_q[i];
    end
endmodule // pcw_reload_mem

// ---- core/pcw_cycle_cfg.sv ----
// pcw_cycle_cfg: pwm cycle configuration register, bank select, cycle overflow
// flag and wide-pwm auto-reload of channel compare values.
// assumes the counter and channel mode logic sit outside, on ref_clk.
// Contract
// R1: bank bit steers compare addresses to reload bank
// R2: reload values used only in pwm modes
// R3: interrupt enable masks the overflow flag
// R4: flag sets on overflow of selected bit
// R5: flag set by hardware or software, sticky
// R6: bit four reads zero, writes ignored
// R7: main overflow copies reload into wide channels
// R8: reload enable global, default off
// R9: cycle code maps to eight..fifteen bits
// R10: wide channels ignore cycle length setting
// R11: irq when flag and enable both set
module pcw_cycle_cfg
    import pcw_pkg::*;
#(
    parameter int CH = PCW_CH_COUNT
)
(
    // clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    rst_n,
    // sfr bus
    input  wire logic                    sfr_wr,
    input  wire logic                    sfr_rd,
    input  wire logic [7:0]              sfr_addr,
    input  wire logic [7:0]              sfr_wdata,
    output logic      [7:0]              sfr_rdata,
    // channel compare access from the sfr decoder
    input  wire logic                    cmp_wr_lo,
    input  wire logic                    cmp_wr_hi,
    input  wire logic                    cmp_rd,
    input  wire logic [$clog2(CH)-1:0]   cmp_ch,
    // counter and channel modes
    input  wire logic [PCW_CNT_W-1:0]    main_array_counter,
    input  wire logic                    cnt_tick,
    input  wire logic [2*CH-1:0]         ch_mode,
    // outputs
    output logic                         cmp_wr_lo_cmp,
    output logic                         cmp_wr_hi_cmp,
    output logic                         cmp_rd_reload,
    output logic      [7:0]              reload_rdata,
    output logic      [CH-1:0]           reload_load,
    output logic      [CH*PCW_CNT_W-1:0] reload_value,
    output logic      [3:0]              cycle_bits,
    output logic                         cycle_overflow_flag,
    output logic                         irq_req
);
    pcw_ctrl_type ctrl_q;
    pcw_ctrl_type ctrl_d;
    logic         flag_q;
    logic         flag_d;
    logic [7:0]   rdata_q;
    logic [7:0]   rld_rdata_q;
    logic [CH-1:0] load_q;

    wire cfg_hit  = sfr_addr == PCW_CFG_ADDR;
    wire cfg_wr   = sfr_wr && cfg_hit;
    wire bank_rld = ctrl_q.bank_sel; // R1
    wire rld_wr_lo = cmp_wr_lo && bank_rld; // R1
    wire rld_wr_hi = cmp_wr_hi && bank_rld; // R1

    function automatic logic bit_of(input logic [PCW_CNT_W-1:0] v, input logic [2:0] code);
        bit_of = v[PCW_MIN_CYCLE - 1 + int'(code)];
    endfunction

    // bit n = 8+code rolls over when bit n-1 falls 1->0 on a counter step
    logic [PCW_CNT_W-1:0] cnt_q;
    wire [PCW_CNT_W-1:0]  cnt_nx = main_array_counter;
    wire cyc_ovf  = cnt_tick && bit_of(cnt_q, ctrl_q.cycle_length_select)
                    && !bit_of(cnt_nx, ctrl_q.cycle_length_select); // R4
    wire main_ovf = cnt_tick && (&cnt_q) && (cnt_nx == '0); // R7

    assign ctrl_d = cfg_wr ? pcw_ctrl_type'({sfr_wdata[PCW_BANK_BIT],
                                             sfr_wdata[PCW_IRQEN_BIT],
                                             sfr_wdata[PCW_RELOAD_BIT],
                                             sfr_wdata[PCW_CYCLE_LENGTH_SELECT_MSB:0]}) : ctrl_q; // R6
    // hardware set wins over a software clear in the same cycle
    assign flag_d = cyc_ovf ? 1'b1
                  : cfg_wr ? sfr_wdata[PCW_FLAG_BIT] : flag_q; // R5

    wire [7:0] cfg_view = {ctrl_q.bank_sel, ctrl_q.irq_en, flag_q, 1'b0,
                           ctrl_q.reload_en, ctrl_q.cycle_length_select}; // R6

    logic [CH*PCW_CNT_W-1:0] rld_all;

    pcw_reload_mem #(.CH(CH)) u_mem (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .wr_lo   (rld_wr_lo),
        .wr_hi   (rld_wr_hi),
        .wr_ch   (cmp_ch),
        .wr_data (sfr_wdata),
        .rd_all  (rld_all)
    );

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_q <= pcw_ctrl_type'(PCW_CFG_RESET[5:0]);
            flag_q <= 1'b0;
            cnt_q  <= '0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            flag_q <= flag_d;
            cnt_q  <= cnt_nx;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_q     <= PCW_CFG_RESET;
            rld_rdata_q <= '0;
        end
        else
        begin
            rdata_q     <= (sfr_rd && cfg_hit) ? cfg_view : 8'h00;
            rld_rdata_q <= sfr_addr[0] ? rld_all[cmp_ch*PCW_CNT_W + 8 +: 8]
                                       : rld_all[cmp_ch*PCW_CNT_W +: 8]; // R1
        end
    end

    // reload strobes only for wide-mode channels with reload enabled
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            load_q <= '0;
        else
            for (int i = 0; i < CH; i++)
                load_q[i] <= main_ovf && ctrl_q.reload_en
                             && (pcw_mode_type'(ch_mode[2*i +: 2]) == PCW_MODE_WIDE); // R7 R8 R2
    end

    assign sfr_rdata           = rdata_q;
    assign reload_rdata        = rld_rdata_q;
    assign cmp_wr_lo_cmp       = cmp_wr_lo && !bank_rld; // R1
    assign cmp_wr_hi_cmp       = cmp_wr_hi && !bank_rld; // R1
    assign cmp_rd_reload       = cmp_rd && bank_rld; // R1
    assign reload_load         = load_q;
    assign reload_value        = rld_all;
    // wide-mode channels read cycle_bits only when not wide
    assign cycle_bits          = 4'(PCW_MIN_CYCLE) + {1'b0, ctrl_q.cycle_length_select}; // R9 R10
    assign cycle_overflow_flag = flag_q;
    assign irq_req             = flag_q && ctrl_q.irq_en; // R3 R11

    property p_irq_mask;
        @(posedge ref_clk) disable iff (!rst_n) !ctrl_q.irq_en |-> !irq_req;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq while masked"); // R3

    property p_irq_on;
        @(posedge ref_clk) disable iff (!rst_n) (flag_q && ctrl_q.irq_en) |-> irq_req;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("irq missing"); // R11

    property p_flag_set;
        @(posedge ref_clk) disable iff (!rst_n) cyc_ovf |=> cycle_overflow_flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set"); // R4

    property p_flag_sticky;
        @(posedge ref_clk) disable iff (!rst_n) (flag_q && !cfg_wr) |=> flag_q;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped"); // R5

    property p_unused_zero;
        @(posedge ref_clk) disable iff (!rst_n)
            (sfr_rd && cfg_hit) |=> !sfr_rdata[PCW_UNUSED_BIT];
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("bit4 nonzero"); // R6

    property p_bank_route;
        @(posedge ref_clk) disable iff (!rst_n) cmp_wr_lo |-> (cmp_wr_lo_cmp != bank_rld);
    endproperty
    a_bank_route: assert property (p_bank_route) else $error("bank misroute"); // R1

    property p_no_reload_off;
        @(posedge ref_clk) disable iff (!rst_n) !ctrl_q.reload_en |=> reload_load == '0;
    endproperty
    a_no_reload_off: assert property (p_no_reload_off) else $error("reload when off"); // R8

    property p_cycle_len;
        @(posedge ref_clk) disable iff (!rst_n)
            cycle_bits == 4'(PCW_MIN_CYCLE) + 4'(ctrl_q.cycle_length_select);
    endproperty
    a_cycle_len: assert property (p_cycle_len) else $error("cycle length wrong"); // R9
endmodule // pcw_cycle_cfg

// ---- testbench/tb_pcw_cycle_cfg.sv ----
// tb_pcw_cycle_cfg: self-checking bench for the pwm cycle configuration block
// assumes pcw_pkg compiled first; inputs change on the falling edge
module tb_pcw_cycle_cfg
    import pcw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk, rst_n, sfr_wr, sfr_rd, cmp_wr_lo, cmp_wr_hi, cmp_rd;
    logic        cnt_tick, wr_lo_c, wr_hi_c, rd_rl, flag, irq_req, clr;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, rl_rdata;
    logic [1:0]  cmp_ch;
    logic [15:0] cnt;
    logic [5:0]  ch_mode;
    logic [2:0]  rl_load, seen;
    logic [47:0] rl_value;
    logic [3:0]  cycle_bits;
    int          mismatches, checked, cycles;

    pcw_cycle_cfg pcw_cycle_cfg_inst (.ref_clk(ref_clk), .rst_n(rst_n), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .cmp_wr_lo(cmp_wr_lo), .cmp_wr_hi(cmp_wr_hi), .cmp_rd(cmp_rd), .cmp_ch(cmp_ch),
        .main_array_counter(cnt), .cnt_tick(cnt_tick), .ch_mode(ch_mode),
        .cmp_wr_lo_cmp(wr_lo_c), .cmp_wr_hi_cmp(wr_hi_c), .cmp_rd_reload(rd_rl),
        .reload_rdata(rl_rdata), .reload_load(rl_load), .reload_value(rl_value),
        .cycle_bits(cycle_bits), .cycle_overflow_flag(flag), .irq_req(irq_req));

    initial
    begin
        ref_clk = 0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // load pulses are caught here so their exact latency does not matter
    always @(posedge ref_clk)
    begin
        seen <= clr ? 3'h0 : seen | rl_load;
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            mismatches++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] d);
        @(negedge ref_clk);
        sfr_wr = 1;
        sfr_addr = PCW_CFG_ADDR;
        sfr_wdata = d;
        @(negedge ref_clk);
        sfr_wr = 0;
    endtask

    task automatic rd(input logic [7:0] exp);
        @(negedge ref_clk);
        sfr_rd = 1;
        sfr_addr = PCW_CFG_ADDR;
        @(negedge ref_clk);
        sfr_rd = 0;
        check("config", {8'h00, sfr_rdata}, {8'h00, exp});
    endtask

    // counter climbs to a then steps to b; no bit falls except at b
    task automatic ovf(input logic [15:0] a, input logic [15:0] b);
        @(negedge ref_clk);
        cnt = a;
        cnt_tick = 1;
        @(negedge ref_clk);
        cnt = b;
        @(negedge ref_clk);
        cnt_tick = 0;
        repeat (2) @(negedge ref_clk);
    endtask

    initial
    begin
        {sfr_wr, sfr_rd, cmp_wr_lo, cmp_wr_hi, cmp_rd, cnt_tick, cmp_ch} = '0;
        {sfr_addr, sfr_wdata, cnt, mismatches, checked} = '0;
        ch_mode = 6'h06;
        clr = 1;
        rst_n = 0;
        repeat (2) @(negedge ref_clk);
        rst_n = 1;
        rd(8'h00);
        wr(8'hFF);
        rd(8'hEF);
        check("irq", irq_req, 1);
        wr(8'h40);
        rd(8'h40);
        check("irq", irq_req, 0);
        for (int c = 0; c < 8; c++)
        begin
            wr(8'(c));
            check("cycle", cycle_bits, 16'(8 + c));
        end
        ovf(16'h00FF, 16'h0100);
        check("flag", flag, 0);
        wr(8'h00);
        ovf(16'h01FF, 16'h0200);
        check("flag", flag, 1);
        check("irq", irq_req, 0);
        wr(8'h60);
        check("irq", irq_req, 1);
        wr(8'h40);
        check("flag", flag, 0);
        @(negedge ref_clk);
        {cmp_wr_lo, cmp_rd} = 2'h3;
        #1 check("lo bank0", {wr_lo_c, rd_rl}, 2'h2);
        wr(8'h80);
        {cmp_rd, sfr_wdata} = {1'b0, 8'h34};
        #1 check("lo bank1", wr_lo_c, 0);
        @(negedge ref_clk);
        {cmp_wr_lo, cmp_wr_hi, sfr_wdata} = {2'h1, 8'h12};
        #1 check("hi bank1", wr_hi_c, 0);
        // the reload store answers through two registers, so let the new byte settle
        @(negedge ref_clk);
        cmp_wr_hi = 0;
        @(negedge ref_clk);
        {cmp_wr_hi, cmp_rd} = 2'h1;
        #1 check("rd bank1", rd_rl, 1);
        @(negedge ref_clk);
        cmp_rd = 0;
        check("reload byte", rl_rdata, 16'h12);
        clr = 0;
        ovf(16'hFFFF, 16'h0000);
        check("no load", seen, 0);
        wr(8'h88);
        ovf(16'hFFFF, 16'h0000);
        check("load", seen, 3'h1);
        check("reload", rl_value[15:0], 16'h1234);
        test_done();
    end
endmodule // tb_pcw_cycle_cfg
